// ### hw/cell_monitor_cfg.svh
`ifndef CELL_MONITOR_CFG_SVH
`define CELL_MONITOR_CFG_SVH

// register offsets
`define ADDR_STATUS      7'h02
`define ADDR_FAULT1      7'h03
`define ADDR_CELL_ALERT  7'h04
`define ADDR_CELL_OVER   7'h05
`define ADDR_CELL_UNDER  7'h07
`define ADDR_BAL_SW      7'h08
`define ADDR_EXTREME     7'h0a
`define ADDR_FAULT2      7'h0b
`define ADDR_ID_LOW      7'h0d
`define ADDR_ID_HIGH     7'h0e
`define ADDR_DEV_CFG     7'h10
`define ADDR_PIN_IO      7'h11
`define ADDR_CHAN_EN     7'h12
`define ADDR_ACQ_CTRL    7'h13

// fault_flags_primary bit positions
`define F1_OSC_A         15
`define F1_OSC_B         14
`define F1_RX_UP         12
`define F1_RX_LO         11
`define F1_RX_UP_B       10
`define F1_RX_LO_B       9
`define F1_SUP3          8
`define F1_SUP2          7
`define F1_GND2          6
`define F1_BALSW         5
`define F1_THERM         4
`define F1_HV_LOW        3
`define F1_GND3          2
`define F1_SUP1          1
`define F1_GND1          0
// software-clearable bits of fault_flags_primary
`define F1_W0C_MASK      16'hc1df

// fault_flags_secondary bit positions
`define F2_HEADROOM      2
`define F2_HV_HIGH       0

// device_config_primary bit positions
`define CFG_FORCE_POR    7
`define CFG_ALIVE        6
`define CFG_ALU_TEST     5
`define CFG_WD_DIS       4
`define CFG_DBL_BUF      3
`define CFG_UNLOCK       1
`define CFG_SOFT_POR     0
`define CFG_RW_MASK      16'hfffc

// acquisition_control bit positions
`define ACQ_DONE         15
`define ACQ_TIMEOUT      14
`define ACQ_READY        13
`define ACQ_MOVE         1
`define ACQ_SCAN         0
`define ACQ_RW_MASK      16'h07f4

// reset values
`define RST_EXTREME_IDX  4'hf
`define RST_CFG          16'h0000
`define RST_UNLOCK       1'b1

// oscillator check interval in clock cycles
`define OSC_EVAL_CYCLES  2'd2

`endif

// ### hw/cell_monitor_pkg.sv
package cell_monitor_pkg;

	// register access from the packet engine
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [6:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	// comparator results for one finished acquisition
	typedef struct packed {
		logic [11:0] over_raw;
		logic [11:0] under_raw;
		logic [1:0]  cold_raw;
		logic [1:0]  hot_raw;
		logic [11:0] balsw_raw;
		logic [3:0]  max_idx;
		logic [3:0]  min_idx;
	} acq_result_t;

	// asynchronous analog monitor and pin levels
	typedef struct packed {
		logic       osc_bad;
		logic [2:0] supply_low;
		logic [2:0] ground_open;
		logic       hv_low;
		logic       hv_high;
		logic       die_hot;
		logic [3:0] pin_in;
	} pin_status_t;

endpackage

// ### hw/cell_monitor_alert_config_regs.sv
`include "cell_monitor_cfg.svh"
// ----------------------------------------------------------------------
// Overview of operation
// - oscillator error sets both flags, write-zero clears
// - supply/ground/hv faults held off while reset flag
// - primary single-ended flags wait for reset flag clear
// - die heat or short settling sets thermal flag
// - combined alert bits are OR of over/under, aux bits OR of cold/hot
// - cell over flag needs enable, refreshed per acquisition
// - cell under flag needs enable, refreshed per acquisition
// - aux cold/hot flags refreshed every acquisition
// - balancing switch flags refreshed, summary ORs them
// - highest/lowest cell index, reset to Fh
// - headroom fault sticky until write zero
// - 24-bit identifier split over two registers
// - rom checksum in upper byte of second id
// - forced reset pulls shutdown input low
// - alive counter enable drives packet engine
// - alu test enable selects test data
// - watchdog disable keeps existing timeout flag
// - double buffer moves results at next start
// - address unlock resets one, cleared by assign
// - pin inputs sampled at address parity end
// - pin three follows balancing timer when overridden
// - no new acquisition while done flag set
// - reset flag set at power-on, write-zero clears
// ----------------------------------------------------------------------
module cell_monitor_alert_config_regs
#(
	parameter logic [23:0] FACTORY_ID = 24'h00_0a5c, // arbitrary value
	parameter logic [7:0]  ROM_CRC    = 8'h3c       // arbitrary value
)
(
	// clock, reset, enable
	input  wire  logic                        core_clk,
	input  wire  logic                        rst,
	input  wire  logic                        ce,
	// register access from the packet engine
	input  wire  cell_monitor_pkg::reg_req_t  reg_req,
	input  wire  logic                        addr_parity_end,
	output logic [15:0]                       reg_rdata,
	// events from the communication and measurement logic
	input  wire  logic                        rx_upper_se,
	input  wire  logic                        rx_lower_se,
	input  wire  logic                        diag_short_settle,
	input  wire  logic                        headroom_low,
	input  wire  logic                        acq_end,
	input  wire  logic                        acq_timeout,
	input  wire  logic                        chain_address_assign_cmd,
	input  wire  cell_monitor_pkg::acq_result_t acq_result,
	input  wire  logic [11:0]                 over_alert_enable,
	input  wire  logic [11:0]                 under_alert_enable,
	input  wire  logic                        balance_timer_running,
	input  wire  logic                        emergency_discharge,
	// asynchronous analog monitors and pins
	input  wire  cell_monitor_pkg::pin_status_t pin_status,
	// pin drivers
	output logic [3:0]                        pin_out_level,
	output logic [3:0]                        pin_out_en,
	// configuration outputs
	output logic                              shutdown_input_pull_low,
	output logic                              alive_counter_enable,
	output logic                              alu_test_enable,
	output logic                              acq_watchdog_enable,
	output logic                              double_buffer_enable,
	output logic                              address_unlock,
	output logic                              soft_reset_req,
	output logic [11:0]                       cell_channel_enable,
	output logic [2:0]                        balance_diag_select,
	// acquisition control
	output logic                              acq_start,
	output logic                              move_results
);
	import cell_monitor_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	pin_status_t sync1_ff;
	pin_status_t sync2_ff;
	logic        osc_phase_ff;
	logic        por_flag_ff;
	logic [15:0] fault1_ff;
	logic [15:0] fault2_ff;
	logic [11:0] over_ff;
	logic [11:0] under_ff;
	logic [1:0]  cold_ff;
	logic [1:0]  hot_ff;
	logic [11:0] balsw_ff;
	logic [3:0]  max_idx_ff;
	logic [3:0]  min_idx_ff;
	logic [15:0] cfg_ff;
	logic        unlock_ff;
	logic [15:0] pin_ctrl_ff;
	logic [3:0]  pin_rd_ff;
	logic [15:0] chan_en_ff;
	logic [15:0] acq_ctrl_ff;
	logic        done_ff;
	logic        timeout_ff;
	logic        ready_ff;
	logic        busy_ff;
	logic        acq_start_ff;
	logic        move_ff;
	logic        soft_reset_ff;
	logic [15:0] rdata_ff;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	logic        wr;
	logic [15:0] wd;
	logic        wr_status;
	logic        wr_fault1;
	logic        wr_fault2;
	logic        wr_cfg;
	logic        wr_pin;
	logic        wr_chan;
	logic        wr_acq;
	logic        scan_req;
	logic        start_ok;
	logic        move_now;
	logic [11:0] over_live;
	logic [11:0] under_live;
	logic [15:0] cell_alert;
	logic [15:0] rd_mux;

	// writes only land while the clock enable is high
	assign wr        = ce & reg_req.wr;
	assign wd        = reg_req.wdata;
	assign wr_status = wr & (reg_req.addr == `ADDR_STATUS);
	assign wr_fault1 = wr & (reg_req.addr == `ADDR_FAULT1);
	assign wr_fault2 = wr & (reg_req.addr == `ADDR_FAULT2);
	assign wr_cfg    = wr & (reg_req.addr == `ADDR_DEV_CFG);
	assign wr_pin    = wr & (reg_req.addr == `ADDR_PIN_IO);
	assign wr_chan   = wr & (reg_req.addr == `ADDR_CHAN_EN);
	assign wr_acq    = wr & (reg_req.addr == `ADDR_ACQ_CTRL);

	// ------------------------------------------------------------------
	// synchronisers for analog monitors and pins
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else if (ce)
		begin
			sync1_ff <= pin_status;
			sync2_ff <= sync1_ff;
		end
	end

	// ------------------------------------------------------------------
	// power-on reset flag
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			por_flag_ff <= 1'b1;
		else if (wr_status && !wd[15])
			por_flag_ff <= 1'b0;
	end

	// oscillator check runs every other cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			osc_phase_ff <= 1'b0;
		else if (ce)
			osc_phase_ff <= ~osc_phase_ff;
	end

	// ------------------------------------------------------------------
	// fault_flags_primary: sticky, set wins over write-zero clear
	// ------------------------------------------------------------------
	logic [15:0] f1_set;
	logic [15:0] f1_clr;
	always_comb
	begin
		f1_set = '0;
		f1_set[`F1_OSC_A]   = osc_phase_ff & sync2_ff.osc_bad;
		f1_set[`F1_OSC_B]   = osc_phase_ff & sync2_ff.osc_bad;
		f1_set[`F1_RX_UP_B] = rx_upper_se;
		f1_set[`F1_RX_LO_B] = rx_lower_se;
		f1_set[`F1_RX_UP]   = fault1_ff[`F1_RX_UP_B] & ~por_flag_ff;
		f1_set[`F1_RX_LO]   = fault1_ff[`F1_RX_LO_B] & ~por_flag_ff;
		f1_set[`F1_SUP1]    = sync2_ff.supply_low[0] & ~por_flag_ff;
		f1_set[`F1_SUP2]    = sync2_ff.supply_low[1] & ~por_flag_ff;
		f1_set[`F1_SUP3]    = sync2_ff.supply_low[2] & ~por_flag_ff;
		f1_set[`F1_GND1]    = sync2_ff.ground_open[0] & ~por_flag_ff;
		f1_set[`F1_GND2]    = sync2_ff.ground_open[1] & ~por_flag_ff;
		f1_set[`F1_GND3]    = sync2_ff.ground_open[2] & ~por_flag_ff;
		f1_set[`F1_HV_LOW]  = sync2_ff.hv_low & ~por_flag_ff;
		f1_set[`F1_THERM]   = sync2_ff.die_hot | diag_short_settle;
		f1_clr = wr_fault1 ? (~wd & `F1_W0C_MASK) : 16'h0000;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			fault1_ff <= '0;
		else if (ce)
			fault1_ff <= (fault1_ff & ~f1_clr) | f1_set;
	end

	// fault_flags_secondary: headroom and hv high
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			fault2_ff <= '0;
		else if (ce)
		begin
			fault2_ff[`F2_HEADROOM] <= (fault2_ff[`F2_HEADROOM]
				& ~(wr_fault2 & ~wd[`F2_HEADROOM])) | headroom_low;
			fault2_ff[`F2_HV_HIGH] <= (fault2_ff[`F2_HV_HIGH]
				& ~(wr_fault2 & ~wd[`F2_HV_HIGH]))
				| (sync2_ff.hv_high & ~por_flag_ff);
		end
	end

	// ------------------------------------------------------------------
	// acquisition flags, refreshed at each acquisition end
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			over_ff  <= '0;
			under_ff <= '0;
			cold_ff  <= '0;
			hot_ff   <= '0;
			balsw_ff <= '0;
		end
		else if (ce && acq_end)
		begin
			over_ff  <= acq_result.over_raw & over_alert_enable;
			under_ff <= acq_result.under_raw & under_alert_enable;
			cold_ff  <= acq_result.cold_raw;
			hot_ff   <= acq_result.hot_raw;
			balsw_ff <= acq_result.balsw_raw;
		end
	end

	// clearing an enable drops the flag at once
	assign over_live  = over_ff & over_alert_enable;
	assign under_live = under_ff & under_alert_enable;
	assign cell_alert = {2'b00, cold_ff[1] | hot_ff[1],
		cold_ff[0] | hot_ff[0], over_live | under_live};

	// extreme cell indices follow the data registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			max_idx_ff <= `RST_EXTREME_IDX;
			min_idx_ff <= `RST_EXTREME_IDX;
		end
		else if (ce && move_ff)
		begin
			max_idx_ff <= acq_result.max_idx;
			min_idx_ff <= acq_result.min_idx;
		end
	end

	// ------------------------------------------------------------------
	// device configuration
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cfg_ff <= `RST_CFG;
		else if (wr_cfg)
			cfg_ff <= wd & `CFG_RW_MASK;
	end

	// address unlock is write-protected
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			unlock_ff <= `RST_UNLOCK;
		else if (ce && chain_address_assign_cmd)
			unlock_ff <= 1'b0;
	end

	// soft reset request is a one-cycle strobe
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			soft_reset_ff <= 1'b0;
		else if (ce)
			soft_reset_ff <= wr_cfg & wd[`CFG_SOFT_POR];
	end

	assign shutdown_input_pull_low = cfg_ff[`CFG_FORCE_POR];
	assign alive_counter_enable    = cfg_ff[`CFG_ALIVE];
	assign alu_test_enable         = cfg_ff[`CFG_ALU_TEST];
	assign acq_watchdog_enable     = ~cfg_ff[`CFG_WD_DIS];
	assign double_buffer_enable    = cfg_ff[`CFG_DBL_BUF];
	assign address_unlock          = unlock_ff;
	assign soft_reset_req          = soft_reset_ff;

	// ------------------------------------------------------------------
	// pin control
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pin_ctrl_ff <= '0;
		else if (wr_pin)
			pin_ctrl_ff <= {wd[15:12], 4'h0, wd[7], 3'b000, wd[3:0]};
	end

	// input levels captured at the address parity point
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pin_rd_ff <= '0;
		else if (ce && addr_parity_end && reg_req.addr == `ADDR_PIN_IO)
			pin_rd_ff <= sync2_ff.pin_in;
	end

	logic pin3_override;
	assign pin3_override = pin_ctrl_ff[7] | emergency_discharge;

	// drive outputs; pin three may follow the balancing timer
	always_comb
	begin
		pin_out_en    = pin_ctrl_ff[15:12];
		pin_out_level = pin_ctrl_ff[15:12] & pin_ctrl_ff[3:0];
		if (pin3_override)
		begin
			pin_out_en[3]    = 1'b1;
			pin_out_level[3] = balance_timer_running;
		end
	end

	// measurement enables
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			chan_en_ff <= '0;
		else if (wr_chan)
			chan_en_ff <= wd;
	end
	assign cell_channel_enable = chan_en_ff[11:0];

	// ------------------------------------------------------------------
	// acquisition control
	// ------------------------------------------------------------------
	assign scan_req = wr_acq & wd[`ACQ_SCAN];
	assign start_ok = scan_req & ~done_ff & ~busy_ff;
	assign move_now = (start_ok & cfg_ff[`CFG_DBL_BUF])
		| (ce & acq_end & ~cfg_ff[`CFG_DBL_BUF])
		| (wr_acq & wd[`ACQ_MOVE] & cfg_ff[`CFG_DBL_BUF] & ~busy_ff);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			acq_ctrl_ff <= '0;
		else if (wr_acq)
			acq_ctrl_ff <= wd & `ACQ_RW_MASK;
	end
	assign balance_diag_select = acq_ctrl_ff[10:8];

	// busy, start and move strobes
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_ff      <= 1'b0;
			acq_start_ff <= 1'b0;
			move_ff      <= 1'b0;
		end
		else if (ce)
		begin
			busy_ff      <= start_ok | (busy_ff & ~acq_end);
			acq_start_ff <= start_ok;
			move_ff      <= move_now;
		end
	end
	assign acq_start    = acq_start_ff;
	assign move_results = move_ff;

	// status flags: set wins over write-zero clear
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			done_ff    <= 1'b0;
			timeout_ff <= 1'b0;
			ready_ff   <= 1'b0;
		end
		else if (ce)
		begin
			done_ff <= (done_ff & ~(wr_acq & ~wd[`ACQ_DONE]))
				| (acq_end & busy_ff);
			timeout_ff <= (timeout_ff & ~(wr_acq & ~wd[`ACQ_TIMEOUT]))
				| (acq_timeout & ~cfg_ff[`CFG_WD_DIS]);
			ready_ff <= (ready_ff & ~(wr_acq & ~wd[`ACQ_READY]))
				| move_ff;
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	always_comb
	begin
		unique case (reg_req.addr)
			`ADDR_STATUS:     rd_mux = {por_flag_ff, |over_live,
				|under_live, 3'b000, |cold_ff, |hot_ff, 6'h00,
				|fault2_ff, (|fault1_ff) | (|balsw_ff)};
			`ADDR_FAULT1:     rd_mux = {fault1_ff[15:6], |balsw_ff,
				fault1_ff[4:0]};
			`ADDR_CELL_ALERT: rd_mux = cell_alert;
			`ADDR_CELL_OVER:  rd_mux = {2'b00, cold_ff, over_live};
			`ADDR_CELL_UNDER: rd_mux = {2'b00, hot_ff, under_live};
			`ADDR_BAL_SW:     rd_mux = {4'h0, balsw_ff};
			`ADDR_EXTREME:    rd_mux = {4'h0, max_idx_ff, 4'h0, min_idx_ff};
			`ADDR_FAULT2:     rd_mux = fault2_ff;
			`ADDR_ID_LOW:     rd_mux = FACTORY_ID[15:0];
			`ADDR_ID_HIGH:    rd_mux = {ROM_CRC, FACTORY_ID[23:16]};
			`ADDR_DEV_CFG:    rd_mux = {cfg_ff[15:2], unlock_ff, 1'b0};
			`ADDR_PIN_IO:     rd_mux = {pin_ctrl_ff[15:12], pin_rd_ff,
				pin_ctrl_ff[7:0]};
			`ADDR_CHAN_EN:    rd_mux = chan_en_ff;
			`ADDR_ACQ_CTRL:   rd_mux = {done_ff, timeout_ff, ready_ff,
				acq_ctrl_ff[12:0]};
			default:          rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rdata_ff <= '0;
		else if (ce && reg_req.rd)
			rdata_ff <= rd_mux;
	end
	assign reg_rdata = rdata_ff;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_osc_sets_both;
		@(posedge core_clk) disable iff (rst)
		ce && osc_phase_ff && sync2_ff.osc_bad
		|=> fault1_ff[`F1_OSC_A] && fault1_ff[`F1_OSC_B];
	endproperty
	a_osc_sets_both: assert property (p_osc_sets_both)
		else $error("oscillator fault flags not set");

	property p_supply_gated;
		@(posedge core_clk) disable iff (rst)
		$rose(fault1_ff[`F1_SUP1]) |-> !$past(por_flag_ff);
	endproperty
	a_supply_gated: assert property (p_supply_gated)
		else $error("supply flag set while reset flag set");

	property p_rx_primary_gated;
		@(posedge core_clk) disable iff (rst)
		$rose(fault1_ff[`F1_RX_UP]) |->
			!$past(por_flag_ff) && $past(fault1_ff[`F1_RX_UP_B]);
	endproperty
	a_rx_primary_gated: assert property (p_rx_primary_gated)
		else $error("primary single-ended flag set early");

	property p_thermal_set;
		@(posedge core_clk) disable iff (rst)
		ce && diag_short_settle |=> fault1_ff[`F1_THERM];
	endproperty
	a_thermal_set: assert property (p_thermal_set)
		else $error("thermal flag missed");

	property p_cell_over_update;
		@(posedge core_clk) disable iff (rst)
		ce && acq_end |=>
			over_ff == $past(acq_result.over_raw & over_alert_enable);
	endproperty
	a_cell_over_update: assert property (p_cell_over_update)
		else $error("cell over flags not refreshed");

	property p_unlock_clear;
		@(posedge core_clk) disable iff (rst)
		$fell(unlock_ff) |-> $past(chain_address_assign_cmd);
	endproperty
	a_unlock_clear: assert property (p_unlock_clear)
		else $error("address unlock cleared without assign");

	sequence s_scan_while_done;
		ce && scan_req && done_ff;
	endsequence
	property p_no_start_when_done;
		@(posedge core_clk) disable iff (rst)
		s_scan_while_done |=> !acq_start;
	endproperty
	a_no_start_when_done: assert property (p_no_start_when_done)
		else $error("acquisition started while done set");

	sequence s_dbl_start;
		ce && start_ok && cfg_ff[`CFG_DBL_BUF];
	endsequence
	property p_dbl_move_at_start;
		@(posedge core_clk) disable iff (rst)
		s_dbl_start |=> acq_start && move_results
			##1 (ready_ff || !$past(ce));
	endproperty
	a_dbl_move_at_start: assert property (p_dbl_move_at_start)
		else $error("double buffer move not at start");

	property p_por_write_one;
		@(posedge core_clk) disable iff (rst)
		por_flag_ff && wr_status && wd[15] |=> por_flag_ff;
	endproperty
	a_por_write_one: assert property (p_por_write_one)
		else $error("reset flag cleared by writing one");

	property p_timeout_kept;
		@(posedge core_clk) disable iff (rst)
		timeout_ff && !wr_acq |=> timeout_ff;
	endproperty
	a_timeout_kept: assert property (p_timeout_kept)
		else $error("timeout flag lost without write");

endmodule

// ### verif/cell_monitor_host_model.sv
// ------------------------------------------------------------------
// packet engine stand-in: issues register reads and writes
// ------------------------------------------------------------------
module cell_monitor_host_model
(
	// register port
	input  wire logic                       core_clk,
	output cell_monitor_pkg::reg_req_t      reg_req,
	input  wire logic [15:0]                reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import cell_monitor_pkg::*;

	initial reg_req = '0;

	// write strobe held over the taking edge, lines scrambled after
	task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_req = '{1'b1, 1'b0, a, d};
		@(negedge core_clk);
		reg_req = '{1'b0, 1'b0, ~a, ~d};
	endtask

	// read strobe, data taken once the answering edge has passed
	task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
		@(negedge core_clk);
		reg_req = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge core_clk);
		reg_req = '{1'b0, 1'b0, ~a, 16'hffff};
		@(negedge core_clk);
		d = reg_rdata;
	endtask
endmodule

// ### verif/cell_monitor_alert_config_regs_test.sv
// ------------------------------------------------------------------
// register bank bench
// ------------------------------------------------------------------
module cell_monitor_alert_config_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cell_monitor_pkg::*;

	logic          core_clk = 1'b0;
	logic          rst      = 1'b1;
	reg_req_t      reg_req;
	logic [15:0]   reg_rdata;
	logic          hdrm = 1'b0, settle = 1'b0, acq_end = 1'b0;
	logic          assign_cmd = 1'b0, emerg = 1'b0, tmr = 1'b0;
	logic [11:0]   ov_en = '0, uv_en = '0;
	acq_result_t   res = '0;
	pin_status_t   pins = '0;
	logic [3:0]    lvl, en;
	logic          sd, alive, alu, unlock, start, seen;
	logic          rxu = 1'b0, ape = 1'b0, tmo = 1'b0;
	logic          wde, dbl, srst, mv;
	logic [2:0]    bds;
	logic [11:0]   chan;
	int            failures = 0, compares = 0, cycles = 0;

	// 25 MHz clock and cycle ceiling
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			finish_test();
		end
	end

	cell_monitor_alert_config_regs i_cell_monitor_alert_config_regs (
		.core_clk(core_clk), .rst(rst), .ce(1'b1), .reg_req(reg_req),
		.addr_parity_end(ape), .reg_rdata(reg_rdata),
		.rx_upper_se(rxu), .rx_lower_se(rxu),
		.diag_short_settle(settle), .headroom_low(hdrm),
		.acq_end(acq_end), .acq_timeout(tmo),
		.chain_address_assign_cmd(assign_cmd), .acq_result(res),
		.over_alert_enable(ov_en), .under_alert_enable(uv_en),
		.balance_timer_running(tmr), .emergency_discharge(emerg),
		.pin_status(pins), .pin_out_level(lvl), .pin_out_en(en),
		.shutdown_input_pull_low(sd), .alive_counter_enable(alive),
		.alu_test_enable(alu), .acq_watchdog_enable(wde),
		.double_buffer_enable(dbl), .address_unlock(unlock),
		.soft_reset_req(srst), .cell_channel_enable(chan),
		.balance_diag_select(bds), .acq_start(start),
		.move_results(mv));

	cell_monitor_host_model i_cell_monitor_host_model (
		.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

	// compare and count
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] d;
		i_cell_monitor_host_model.read_reg(a, d);
		check(d, e);
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		i_cell_monitor_host_model.write_reg(a, d);
		repeat (4) @(negedge core_clk);
	endtask

	// watch for a start pulse over a few cycles
	task automatic watch_start();
		seen = (start === 1'b1);
		repeat (8) @(negedge core_clk) if (start === 1'b1) seen = 1'b1;
	endtask

	task automatic finish_test();
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk) rst = 1'b0;
		rd(7'h0a, 16'h0f0f);
		rd(7'h0d, 16'h0a5c);
		rd(7'h0e, 16'h3c00);
		rd(7'h10, 16'h0002);
		pins = 14'h3ff0;
		@(negedge core_clk) rxu = 1'b1;
		@(negedge core_clk) rxu = 1'b0;
		wr(7'h02, 16'hffff);
		rd(7'h03, 16'hc610);
		rd(7'h0b, 16'h0000);
		rd(7'h02, 16'h8001);
		wr(7'h02, 16'h0000);
		rd(7'h03, 16'hdfdf);
		rd(7'h0b, 16'h0001);
		pins = '0;
		wr(7'h03, 16'hffff);
		rd(7'h03, 16'hdfdf);
		wr(7'h03, 16'h0000);
		rd(7'h03, 16'h1e00);
		@(negedge core_clk) {hdrm, settle} = 2'b11;
		@(negedge core_clk) {hdrm, settle} = 2'b00;
		rd(7'h0b, 16'h0005);
		rd(7'h03, 16'h1e10);
		wr(7'h11, 16'h1001);
		check({8'h00, en, lvl}, 16'h0011);
		{emerg, tmr} = 2'b11;
		@(negedge core_clk) check({8'h00, en, lvl}, 16'h0099);
		{ape, pins} = {1'b1, 14'h0005};
		repeat (2) @(negedge core_clk);
		rd(7'h11, 16'h1001);
		rd(7'h11, 16'h1501);
		{ape, pins} = '0;
		wr(7'h10, 16'h00e0);
		check({13'h0000, sd, alive, alu}, 16'h0007);
		check({13'h0000, srst, dbl, wde}, 16'h0001);
		@(negedge core_clk) assign_cmd = 1'b1;
		@(negedge core_clk) assign_cmd = 1'b0;
		check({15'h0000, unlock}, 16'h0000);
		rd(7'h10, 16'h00e0);
		{ov_en, uv_en} = '1;
		res = '{12'h801, 12'h002, 2'b01, 2'b10, 12'h004, 4'h3, 4'h5};
		i_cell_monitor_host_model.write_reg(7'h13, 16'h0001);
		watch_start();
		check({15'h0000, seen}, 16'h0001);
		@(negedge core_clk) {acq_end, tmo} = 2'b11;
		@(negedge core_clk) {acq_end, tmo} = 2'b00;
		repeat (4) @(negedge core_clk);
		rd(7'h05, 16'h1801);
		rd(7'h07, 16'h2002);
		rd(7'h04, 16'h3803);
		rd(7'h08, 16'h0004);
		rd(7'h0a, 16'h0305);
		rd(7'h03, 16'h1e30);
		wr(7'h10, 16'h00f0);
		rd(7'h13, 16'he000);
		i_cell_monitor_host_model.write_reg(7'h13, 16'h0001);
		watch_start();
		check({15'h0000, seen}, 16'h0000);
		@(negedge core_clk) tmo = 1'b1;
		@(negedge core_clk) tmo = 1'b0;
		rd(7'h13, 16'h0000);
		wr(7'h12, 16'habcd);
		check({4'h0, chan}, 16'h0bcd);
		{res.max_idx, res.min_idx} = 8'h72;
		i_cell_monitor_host_model.write_reg(7'h10, 16'h00f9);
		check({13'h0000, srst, dbl, wde}, 16'h0006);
		i_cell_monitor_host_model.write_reg(7'h13, 16'h0201);
		check({11'h000, bds, start, mv}, 16'h000b);
		rd(7'h0a, 16'h0702);
		rd(7'h13, 16'h2200);
		finish_test();
	end
endmodule
